/* File: hw/cet_cfg.svh */
// Register map, reset values, field positions and timing constants of the emulation timeout bank
`ifndef CET_CFG_SVH
`define CET_CFG_SVH

// Register indices; the byte address is four times the index
`define CET_IDX_MASK 8'h21
`define CET_IDX_STD 8'h22
`define CET_IDX_LGA 8'h23
`define CET_IDX_LGB 8'h24
`define CET_IDX_CTRL 8'h25
`define CET_IDX_STAT 8'h26
`define CET_IDX_NONE 8'hFF

// Reset values
`define CET_RST_MASK 8'h00
`define CET_RST_STD 8'h10
`define CET_RST_LGA 8'h6C
`define CET_RST_LGB 8'h01
`define CET_RST_CTRL 8'h00

// Implemented bits per register
`define CET_WM_MASK 8'h7F
`define CET_WM_STD 8'h3F
`define CET_WM_LGA 8'hFF
`define CET_WM_LGB 8'h3F
`define CET_WM_CTRL 8'h01

// Field positions
`define CET_DCP_MSB 5
`define CET_DCP_LSB 4
`define CET_L1_MSB 7
`define CET_L1_LSB 6
`define CET_L2_MSB 5
`define CET_L2_LSB 4
`define CET_L3_MSB 3
`define CET_L3_LSB 2
`define CET_L4_MSB 1
`define CET_L4_LSB 0
`define CET_L1_DIS 0
`define CET_L2_DIS 1
`define CET_L3_DIS 2
`define CET_L4_DIS 3
`define CET_CTRL_TO_DIS 0

// Timeout periods in milliseconds, counted in ticks of a fixed prescaler
`define CET_T0_MS 800
`define CET_T1_MS 1600
`define CET_T2_MS 6400
`define CET_T3_MS 12800
`define CET_TICK_MS 100
`define CET_CLK_NS 10
`define CET_NS_PER_MS 1000000
`define CET_TICK_CYCLES (`CET_TICK_MS * `CET_NS_PER_MS / `CET_CLK_NS)
`define CET_T0_TICKS (`CET_T0_MS / `CET_TICK_MS)
`define CET_T1_TICKS (`CET_T1_MS / `CET_TICK_MS)
`define CET_T2_TICKS (`CET_T2_MS / `CET_TICK_MS)
`define CET_T3_TICKS (`CET_T3_MS / `CET_TICK_MS)

`endif

/* File: hw/cet_pkg.sv */
// Types shared by the emulation timeout bank and its timer
package cet_pkg;

    typedef enum logic [2:0] {
        CET_PROF_DCP = 3'h0,
        CET_PROF_L1 = 3'h1,
        CET_PROF_L2 = 3'h2,
        CET_PROF_L3 = 3'h3,
        CET_PROF_L4 = 3'h4
    } cet_prof_e;

    typedef enum logic [1:0] {
        CET_TM_IDLE = 2'h0,
        CET_TM_RUN = 2'h1,
        CET_TM_DONE = 2'h3
    } cet_tm_e;

    typedef struct packed {
        logic apply;
        cet_prof_e prof;
    } cet_req_s;

    typedef struct packed {
        logic active;
        logic expired;
        logic skipped;
        cet_prof_e prof;
        logic [1:0] sel;
    } cet_stat_s;

    typedef struct packed {
        logic [7:0] mask;
        logic [7:0] std;
        logic [7:0] lga;
        logic [7:0] lgb;
        logic [7:0] ctrl;
    } cet_regs_s;

endpackage

/* File: hw/cet_timer.sv */
// Emulation timeout counter: prescaled tick counter with restart and stop
`timescale 1ns/1ps
`include "cet_cfg.svh"

module cet_timer
    import cet_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `CET_TICK_CYCLES,
    parameter int unsigned CNT_W = 8
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic start,
    input wire logic stop,
    input wire logic [CNT_W-1:0] ticks,
    output logic busy,
    output logic expired
);

    localparam int unsigned PW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
    localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);

    if (TICK_CYCLES < 2) begin : g_chk_tick
        $error("cet_timer: TICK_CYCLES must be at least 2");
    end
    if (CNT_W < 8) begin : g_chk_cnt
        $error("cet_timer: CNT_W too narrow for the longest period");
    end

    cet_tm_e st_q, st_d;
    logic [PW-1:0] pre_q, pre_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;

    always_comb begin
        st_d = st_q;
        pre_d = pre_q;
        cnt_d = cnt_q;
        case (st_q)
            CET_TM_IDLE: begin
                st_d = CET_TM_IDLE;
            end
            CET_TM_RUN: begin
                if (pre_q == PRE_LAST) begin
                    pre_d = '0;
                    if (cnt_q <= CNT_W'(1)) begin
                        st_d = CET_TM_DONE;
                    end else begin
                        cnt_d = cnt_q - CNT_W'(1);
                    end
                end else begin
                    pre_d = pre_q + PW'(1);
                end
            end
            CET_TM_DONE: begin
                st_d = CET_TM_IDLE;
            end
            default: begin
                st_d = CET_TM_IDLE;
            end
        endcase
        // A new profile restarts from a full period, prescaler included, unless stop is set in the same cycle
        if (start) begin
            st_d = CET_TM_RUN;
            pre_d = '0;
            cnt_d = ticks;
        end
        if (stop) begin
            st_d = CET_TM_IDLE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_q <= CET_TM_IDLE;
            pre_q <= '0;
            cnt_q <= '0;
        end else begin
            st_q <= st_d;
            pre_q <= pre_d;
            cnt_q <= cnt_d;
        end
    end

    assign busy = (st_q == CET_TM_RUN);
    assign expired = (st_q == CET_TM_DONE);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    a_tmr_restart_load: assert property (
        start && !stop |=> busy && cnt_q == $past(ticks) && pre_q == '0)
        else $error("timer did not reload on start");

    a_tmr_expire_end: assert property (
        busy && cnt_q == CNT_W'(1) && pre_q == PRE_LAST && !start && !stop
            |=> expired ##1 !expired && busy == $past(start && !stop))
        else $error("timer did not expire after its last tick");

endmodule

/* File: hw/cet_top.sv */
// Charger emulation timeout configuration bank with AHB-Lite register slave
`timescale 1ns/1ps
`include "cet_cfg.svh"

// Functional notes
// - Applied profile uses its own timeout field
// - Global disable ignores all timeout fields
// - Register contents kept through Sleep
// - Dedicated field bits 5-4: 0.8/1.6/6.4/12.8 s
// - Legacy one field bits 7-6, four periods
// - Legacy two field bits 5-4, four periods
// - Legacy three field bits 3-2, four periods
// - Legacy four field bits 1-0, four periods
// - Legacy disable bit excludes profile from emulation

module cet_top
    import cet_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `CET_TICK_CYCLES
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire cet_req_s prof_req,
    output cet_stat_s emu_stat
);

    localparam int unsigned CNT_W = 8;

    // A one-cycle prescaler would leave the timer no cycle to tell ticks apart
    if (TICK_CYCLES < 2) begin : g_chk_tick
        $error("cet_top: TICK_CYCLES must be at least 2");
    end

    cet_regs_s regs_q, regs_d;
    logic wr_pend_q, wr_pend_d;
    logic [7:0] idx_q, idx_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic [7:0] rd_byte;
    logic addr_take;
    logic addr_hit;

    logic [1:0] fld_sel;
    logic prof_en;
    logic to_dis;
    logic tmr_start;
    logic [CNT_W-1:0] tmr_ticks;
    logic tmr_busy;
    logic tmr_expired;
    logic skip_q, skip_d;
    cet_prof_e prof_q, prof_d;
    logic [1:0] sel_q, sel_d;

    // Zero-wait slave: every transfer completes in its first data phase
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    assign addr_take = hsel && htrans[1] && hready;
    assign addr_hit = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
    assign to_dis = regs_q.ctrl[`CET_CTRL_TO_DIS];

    // Bus and register state
    always_comb begin
        regs_d = regs_q;
        wr_pend_d = 1'b0;
        idx_d = idx_q;
        hrdata_d = hrdata_q;
        rd_byte = 8'h00;
        if (wr_pend_q) begin
            case (idx_q)
                `CET_IDX_MASK: regs_d.mask = hwdata[7:0] & `CET_WM_MASK;
                `CET_IDX_STD: regs_d.std = hwdata[7:0] & `CET_WM_STD;
                `CET_IDX_LGA: regs_d.lga = hwdata[7:0] & `CET_WM_LGA;
                `CET_IDX_LGB: regs_d.lgb = hwdata[7:0] & `CET_WM_LGB;
                `CET_IDX_CTRL: regs_d.ctrl = hwdata[7:0] & `CET_WM_CTRL;
                default: regs_d = regs_q;
            endcase
        end
        if (addr_take) begin
            idx_d = addr_hit ? haddr[9:2] : `CET_IDX_NONE;
            wr_pend_d = hwrite;
            // Read from the post-write values so a read right behind a write sees it
            case (addr_hit ? haddr[9:2] : `CET_IDX_NONE)
                `CET_IDX_MASK: rd_byte = regs_d.mask;
                `CET_IDX_STD: rd_byte = regs_d.std;
                `CET_IDX_LGA: rd_byte = regs_d.lga;
                `CET_IDX_LGB: rd_byte = regs_d.lgb;
                `CET_IDX_CTRL: rd_byte = regs_d.ctrl;
                `CET_IDX_STAT: rd_byte = {tmr_busy, prof_q, 2'h0, sel_q};
                default: rd_byte = 8'h00;
            endcase
            hrdata_d = hwrite ? 32'h0 : {24'h0, rd_byte};
        end
    end

    // Only the synchronous power-on reset touches the bank; sleep leaves it alone
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            regs_q <= '{mask: `CET_RST_MASK, std: `CET_RST_STD, lga: `CET_RST_LGA,
                        lgb: `CET_RST_LGB, ctrl: `CET_RST_CTRL};
            wr_pend_q <= 1'b0;
            idx_q <= `CET_IDX_NONE;
            hrdata_q <= 32'h0;
        end else begin
            regs_q <= regs_d;
            wr_pend_q <= wr_pend_d;
            idx_q <= idx_d;
            hrdata_q <= hrdata_d;
        end
    end

    // Field lookup for the profile being applied
    always_comb begin
        fld_sel = 2'h0;
        prof_en = 1'b0;
        case (prof_req.prof)
            CET_PROF_DCP: begin
                fld_sel = regs_q.std[`CET_DCP_MSB:`CET_DCP_LSB];
                prof_en = 1'b1;
            end
            CET_PROF_L1: begin
                fld_sel = regs_q.lga[`CET_L1_MSB:`CET_L1_LSB];
                prof_en = !regs_q.mask[`CET_L1_DIS];
            end
            CET_PROF_L2: begin
                fld_sel = regs_q.lga[`CET_L2_MSB:`CET_L2_LSB];
                prof_en = !regs_q.mask[`CET_L2_DIS];
            end
            CET_PROF_L3: begin
                fld_sel = regs_q.lga[`CET_L3_MSB:`CET_L3_LSB];
                prof_en = !regs_q.mask[`CET_L3_DIS];
            end
            CET_PROF_L4: begin
                fld_sel = regs_q.lga[`CET_L4_MSB:`CET_L4_LSB];
                prof_en = !regs_q.mask[`CET_L4_DIS];
            end
            default: begin
                fld_sel = 2'h0;
                prof_en = 1'b0;
            end
        endcase
    end

    // Same code map for all five fields; code 11 is the longest period
    always_comb begin
        case (fld_sel)
            2'h0: tmr_ticks = CNT_W'(`CET_T0_TICKS);
            2'h1: tmr_ticks = CNT_W'(`CET_T1_TICKS);
            2'h2: tmr_ticks = CNT_W'(`CET_T2_TICKS);
            2'h3: tmr_ticks = CNT_W'(`CET_T3_TICKS);
            default: tmr_ticks = CNT_W'(`CET_T0_TICKS);
        endcase
    end

    assign tmr_start = prof_req.apply && prof_en && !to_dis;

    // Applied-profile status
    always_comb begin
        prof_d = prof_q;
        sel_d = sel_q;
        skip_d = prof_req.apply && !prof_en;
        if (tmr_start) begin
            prof_d = prof_req.prof;
            sel_d = fld_sel;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            prof_q <= CET_PROF_DCP;
            sel_q <= 2'h0;
            skip_q <= 1'b0;
        end else begin
            prof_q <= prof_d;
            sel_q <= sel_d;
            skip_q <= skip_d;
        end
    end

    // Disable also halts a period already running
    cet_timer #(
        .TICK_CYCLES(TICK_CYCLES),
        .CNT_W(CNT_W)
    ) u_timer (
        .sys_clk(sys_clk),
        .srst(srst),
        .start(tmr_start),
        .stop(to_dis),
        .ticks(tmr_ticks),
        .busy(tmr_busy),
        .expired(tmr_expired)
    );

    assign emu_stat = '{active: tmr_busy, expired: tmr_expired, skipped: skip_q,
                        prof: prof_q, sel: sel_q};

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    sequence s_apply_dcp;
        prof_req.apply && prof_req.prof == CET_PROF_DCP && !to_dis;
    endsequence

    sequence s_apply_leg(cet_prof_e p);
        prof_req.apply && prof_req.prof == p && !to_dis;
    endsequence

    property p_leg_field(cet_prof_e p, logic dis_bit, logic [1:0] fld);
        s_apply_leg(p) ##0 !dis_bit |=> emu_stat.active && emu_stat.prof == p && emu_stat.sel == $past(fld);
    endproperty

    a_dcp_field_use: assert property (
        s_apply_dcp |=> emu_stat.active && emu_stat.prof == CET_PROF_DCP
            && emu_stat.sel == $past(regs_q.std[`CET_DCP_MSB:`CET_DCP_LSB]))
        else $error("dedicated profile did not take its own field");

    a_dcp_code_map: assert property (
        s_apply_dcp ##0 (regs_q.std[`CET_DCP_MSB:`CET_DCP_LSB] != 2'h3)
            |-> tmr_start && tmr_ticks == (regs_q.std[`CET_DCP_MSB] ? CNT_W'(`CET_T2_TICKS)
            : regs_q.std[`CET_DCP_LSB] ? CNT_W'(`CET_T1_TICKS) : CNT_W'(`CET_T0_TICKS)))
        else $error("dedicated code mapped to wrong period");

    a_dcp_code_top: assert property (
        s_apply_dcp ##0 (regs_q.std[`CET_DCP_MSB:`CET_DCP_LSB] == 2'h3)
            |-> tmr_ticks == CNT_W'(`CET_T3_TICKS))
        else $error("dedicated code 11 not the longest period");

    a_dis_no_run: assert property (
        to_dis |=> !emu_stat.active && !emu_stat.expired)
        else $error("timeout ran while globally disabled");

    a_sleep_bank_hold: assert property (
        !wr_pend_q |=> regs_q == $past(regs_q))
        else $error("register bank changed without a write");

    a_leg_one_field: assert property (
        p_leg_field(CET_PROF_L1, regs_q.mask[`CET_L1_DIS], regs_q.lga[`CET_L1_MSB:`CET_L1_LSB]))
        else $error("legacy one field not applied");

    a_leg_two_field: assert property (
        p_leg_field(CET_PROF_L2, regs_q.mask[`CET_L2_DIS], regs_q.lga[`CET_L2_MSB:`CET_L2_LSB]))
        else $error("legacy two field not applied");

    a_leg_three_field: assert property (
        p_leg_field(CET_PROF_L3, regs_q.mask[`CET_L3_DIS], regs_q.lga[`CET_L3_MSB:`CET_L3_LSB]))
        else $error("legacy three field not applied");

    a_leg_four_field: assert property (
        p_leg_field(CET_PROF_L4, regs_q.mask[`CET_L4_DIS], regs_q.lga[`CET_L4_MSB:`CET_L4_LSB]))
        else $error("legacy four field not applied");

    a_mask_skip_prof: assert property (
        prof_req.apply && prof_req.prof == CET_PROF_L2 && regs_q.mask[`CET_L2_DIS]
            |-> !tmr_start ##1 emu_stat.skipped)
        else $error("masked legacy profile was applied");

    // Bus side: a read shows the stored byte, a write lands at the end of its data phase
    sequence s_std_read;
        addr_take && !hwrite && addr_hit && haddr[9:2] == `CET_IDX_STD && !wr_pend_q;
    endsequence

    sequence s_lga_write;
        addr_take && hwrite && addr_hit && haddr[9:2] == `CET_IDX_LGA;
    endsequence

    a_std_read_back: assert property (
        s_std_read |=> hrdata == {24'h0, $past(regs_q.std)})
        else $error("standard timeout register read back wrong");

    a_lga_write_land: assert property (
        s_lga_write |=> ##1 regs_q.lga == $past(hwdata[7:0]))
        else $error("legacy timeout write did not land");

    // Profile side: only a started period may change the reported profile and code
    a_run_sel_hold: assert property (
        emu_stat.active && !tmr_start |=> emu_stat.sel == $past(emu_stat.sel)
            && emu_stat.prof == $past(emu_stat.prof))
        else $error("running period changed its code");

    a_expire_one_pulse: assert property (
        emu_stat.expired |=> !emu_stat.expired)
        else $error("expiry pulse longer than one cycle");

    a_skip_keeps_run: assert property (
        prof_req.apply && !prof_en |=> emu_stat.skipped && emu_stat.sel == $past(sel_q)
            && emu_stat.prof == $past(prof_q))
        else $error("masked profile disturbed the running period");

    a_dis_apply_none: assert property (
        prof_req.apply && to_dis |=> emu_stat.sel == $past(sel_q)
            && emu_stat.prof == $past(prof_q))
        else $error("profile applied while globally disabled");

endmodule

/* File: sim/charger_emulation_timeout_config_tb.sv */
// Self-checking testbench for the emulation timeout bank
`timescale 1ns/1ps
`include "cet_cfg.svh"

module charger_emulation_timeout_config_tb;
    import cet_pkg::*;

    // Short prescaler so the longest period is 512 cycles
    localparam int unsigned TCK = 4;

    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    cet_req_s prof_req = '0;
    cet_stat_s emu_stat;
    int err_total = 0;
    int total_checks = 0;
    int cyc = 0;

    assign hready = hreadyout;

    cet_top #(.TICK_CYCLES(TCK)) i_dut (
        .sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .prof_req(prof_req), .emu_stat(emu_stat)
    );

    always #5 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Bounded wait: the bus never stalls, but a broken slave must not hang the run
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        if (n >= 100) begin
            chk("hready_wait", 32'h1, 32'h0);
        end
    endtask

    task automatic bus(input logic [7:0] idx, input logic we, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge sys_clk);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        htrans <= 2'h2;
        hwrite <= we;
        wait_ready();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= we ? wd : 32'h0;
        wait_ready();
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        logic [31:0] d;
        bus(idx, 1'b1, wd, d);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [31:0] e);
        logic [31:0] d;
        bus(idx, 1'b0, 32'h0, d);
        chk(nm, e, d);
    endtask

    // Returns at the edge that takes the request
    task automatic apply(input int p);
        @(posedge sys_clk);
        prof_req <= '{1'b1, cet_prof_e'(p)};
        @(posedge sys_clk);
        prof_req <= '{1'b0, cet_prof_e'(p)};
    endtask

    function automatic int per_cyc(input logic [1:0] c);
        case (c)
            2'h0: return `CET_T0_TICKS * TCK;
            2'h1: return `CET_T1_TICKS * TCK;
            2'h2: return `CET_T2_TICKS * TCK;
            default: return `CET_T3_TICKS * TCK;
        endcase
    endfunction

    task automatic run_per(input int p, input logic [1:0] sel);
        int t0;
        int n;
        apply(p);
        #1;
        t0 = cyc;
        chk("active", 32'h1, {31'h0, emu_stat.active});
        chk("prof", p, {29'h0, emu_stat.prof});
        chk("sel", {30'h0, sel}, {30'h0, emu_stat.sel});
        n = 0;
        while (emu_stat.expired !== 1'b1 && n < 2000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk("period", per_cyc(sel), cyc - t0);
        chk("active_end", 32'h0, {31'h0, emu_stat.active});
    endtask

    task automatic t_reset();
        rd_chk("mask_rst", `CET_IDX_MASK, 32'h00);
        rd_chk("std_rst", `CET_IDX_STD, 32'h10);
        rd_chk("lga_rst", `CET_IDX_LGA, 32'h6C);
        rd_chk("lgb_rst", `CET_IDX_LGB, 32'h01);
        rd_chk("unmapped", `CET_IDX_NONE, 32'h0);
        wr(`CET_IDX_LGB, 32'hFFFF_FFFF);
        rd_chk("lgb_rw", `CET_IDX_LGB, 32'h3F);
        repeat (20) @(posedge sys_clk);
        rd_chk("lgb_kept", `CET_IDX_LGB, 32'h3F);
        $display("test reset done");
    endtask

    task automatic t_dedicated();
        for (int c = 0; c < 4; c++) begin
            // Reserved low nibble is written back with its reset contents
            wr(`CET_IDX_STD, {26'h0, 2'(c), 4'h0});
            run_per(0, 2'(c));
        end
        $display("test dedicated done");
    endtask

    task automatic t_legacy();
        logic [1:0] cc;
        logic [7:0] v;
        for (int p = 1; p <= 4; p++) begin
            for (int c = 0; c < 4; c++) begin
                cc = 2'(c);
                v = {4{~cc}};
                v[8 - 2 * p +: 2] = cc;
                wr(`CET_IDX_LGA, {24'h0, v});
                run_per(p, cc);
            end
        end
        $display("test legacy done");
    endtask

    task automatic t_mask();
        for (int p = 1; p <= 4; p++) begin
            wr(`CET_IDX_MASK, 32'h1 << (p - 1));
            apply(p);
            #1;
            chk("skipped", 32'h1, {31'h0, emu_stat.skipped});
            chk("not_active", 32'h0, {31'h0, emu_stat.active});
        end
        apply(5);
        #1;
        chk("bad_prof", 32'h1, {31'h0, emu_stat.skipped});
        wr(`CET_IDX_MASK, 32'h0F);
        wr(`CET_IDX_STD, 32'h00);
        run_per(0, 2'h0);
        wr(`CET_IDX_MASK, 32'h00);
        $display("test mask done");
    endtask

    task automatic t_disable();
        int seen;
        wr(`CET_IDX_CTRL, 32'h1);
        apply(0);
        #1;
        chk("dis_ignored", 32'h0, {31'h0, emu_stat.active});
        wr(`CET_IDX_CTRL, 32'h0);
        apply(0);
        repeat (5) @(posedge sys_clk);
        wr(`CET_IDX_CTRL, 32'h1);
        seen = 0;
        repeat (60) begin
            @(posedge sys_clk);
            #1;
            seen += emu_stat.expired === 1'b1 ? 1 : 0;
        end
        chk("dis_stopped", 32'h0, {31'h0, emu_stat.active});
        chk("dis_no_expiry", 32'h0, seen);
        wr(`CET_IDX_CTRL, 32'h0);
        $display("test disable done");
    endtask

    task automatic t_restart();
        wr(`CET_IDX_LGA, 32'h30);
        apply(1);
        repeat (10) @(posedge sys_clk);
        // The running 0.8 s period must be dropped for the new profile's 12.8 s
        run_per(2, 2'h3);
        apply(2);
        repeat (3) @(posedge sys_clk);
        rd_chk("status", `CET_IDX_STAT, {24'h0, 1'b1, 3'h2, 2'h0, 2'h3});
        $display("test restart done");
    endtask

    initial begin
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        t_reset();
        t_dedicated();
        t_legacy();
        t_mask();
        t_disable();
        t_restart();
        final_report();
    end

    initial begin
        repeat (40000) @(posedge sys_clk);
        err_total++;
        $display("mismatch watchdog expected end seen timeout");
        final_report();
    end

endmodule
